// ===== hw/scrw_pkg.sv
`default_nettype none
package scrw_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_TMR_CFG  = 8'h31;
  localparam logic [7:0] ADDR_PIN_CFG  = 8'h32;
  localparam logic [7:0] ADDR_LOCK_CFG = 8'h39;
  localparam logic [7:0] ADDR_WDT_CLR  = 8'hE3;
  localparam logic [7:0] ADDR_STATUS   = 8'hFF;

  // ==========================================================================
  // reset values and write masks
  localparam logic [7:0] TMR_CFG_RST   = 8'h8F;
  localparam logic [7:0] PIN_CFG_RST   = 8'h00;
  localparam logic [7:0] LOCK_CFG_RST  = 8'h00;
  localparam logic [7:0] STATUS_POR    = 8'h10;
  localparam logic [7:0] PIN_CFG_WMASK = 8'h1F;
  localparam logic [7:0] LOCK_WMASK    = 8'h03;
  localparam logic [7:0] WDT_CLR_KEY   = 8'h38;

  // ==========================================================================
  // field positions
  localparam int LOCK_DIS_BIT  = 0;
  localparam int LOCK_FINE_BIT = 1;
  localparam int ST_STOP_BIT   = 0;
  localparam int ST_SLEEP_BIT  = 3;
  localparam int ST_POWER_ON_FLAG_BIT   = 4;
  localparam int ST_WATCHDOG_RESET_FLAG_BIT   = 5;
  localparam int ST_GLOBAL_INTERRUPT_STATUS_BIT   = 7;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned HOLDOFF_MS    = 20;
  localparam int unsigned HOLDOFF_CYC   = CLK_HZ / 1000 * HOLDOFF_MS;
  localparam int unsigned WAKE_SLOW_CYC = 3;
  localparam logic [1:0]  WDT_LIMIT     = 2'h3;
  localparam int unsigned FILT_CYC      = 2;
  localparam int unsigned SLEEP_DIV_DEF = 64;
  localparam logic [3:0]  TRIM_CRS_RST  = 4'h8;
  localparam logic [5:0]  TRIM_FINE_RST = 6'h20;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    SRC_INT24 = 2'b00,
    SRC_EXT   = 2'b01,
    SRC_SLOW  = 2'b10,
    SRC_ALT   = 2'b11
  } scrw_src_t;

  typedef struct packed {
    logic [1:0] cap_div;
    scrw_src_t  cap_sel;
    logic [1:0] itm_div;
    scrw_src_t  itm_sel;
  } scrw_tmr_cfg_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       xtal_sel;
    logic       xtal_en;
    logic       filt_dis;
    scrw_src_t  out_sel;
  } scrw_pin_cfg_t;

  typedef struct packed {
    logic [3:0] coarse;
    logic [5:0] fine;
  } scrw_trim_t;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b000,
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE  = 3'b011,
    ST_STOP  = 3'b100
  } scrw_cpu_state_t;

endpackage
`default_nettype wire

// ===== hw/scrw_top.sv
// Summary of operation
// (RULE1) fine-tune-only bit skips coarse trim steps
// (RULE2) lock disable stops packet-based oscillator trimming
// (RULE3) capture clock divides by 2,4,6,8
// (RULE4) capture clock source: int, ext, slow, off
// (RULE5) interval clock divides by 1,2,3,4
// (RULE6) interval clock source: int, ext, slow, capture
// (RULE7) crystal enable picks crystal, kills pin drivers
// (RULE8) firmware enables crystal before selecting it
// (RULE9) filter-disable bit bypasses external input filter
// (RULE10) clock-out pin source select
// (RULE11) sleep forces internal osc, wake after three
// (RULE12) any reset restores register defaults
// (RULE13) reset starts cpu at zero, internal clock
// (RULE14) hold cpu 20 ms after power-on
// (RULE15) watchdog flag set by hardware, sw clears
// (RULE16) power-on flag set at power-on, sw clears
// (RULE17) clearing power-on flag arms watchdog
// (RULE18) sleep bit sleeps cpu until interrupt
// (RULE19) stop bit halts cpu until reset
// (RULE20) sleep timer overflow raises sleep interrupt
// (RULE21) watchdog resets after three timer overflows
// (RULE22) watchdog-clear write clears count, 0x38 timer
// (RULE23) watchdog-clear register is write-only at 0xE3
// (RULE24) reserved bits ignore writes, read zero
//
`default_nettype none
module scrw_top #(
  parameter int unsigned HOLD_CYCLES = scrw_pkg::HOLDOFF_CYC,
  parameter int unsigned SLEEP_DIV   = scrw_pkg::SLEEP_DIV_DEF
) (
  input  wire logic       I_CLK_SYS,        // system clock
  input  wire logic       I_RST,            // power-on reset
  input  wire logic [7:0] I_ADDR,           // register address
  input  wire logic [7:0] I_WDATA,          // write data
  input  wire logic       I_WR,             // write strobe
  input  wire logic       I_RD,             // read strobe
  output logic      [7:0] O_RDATA,          // read data
  input  wire logic       I_OSC24,          // internal fast oscillator
  input  wire logic       I_OSC32K,         // internal slow oscillator
  input  wire logic       I_XTAL_CLK,       // crystal oscillator block
  input  wire logic       I_EXTERNAL_CLOCK_INPUT_PIN,      // shared pin clock input
  input  wire logic       I_USB_INT_SRC,    // usb clocked by internal osc
  input  wire logic       I_PKT_DONE,       // packet timing sample
  input  wire logic       I_PKT_FAST,       // oscillator ran fast
  input  wire logic       I_PKT_FAR,        // error needs coarse step
  input  wire logic       I_IRQ_PENDING,    // any interrupt pending
  input  wire logic       I_GIE,            // cpu global enable
  output logic      [3:0] O_TRIM_COARSE,    // coarse oscillator trim
  output logic      [5:0] O_TRIM_FINE,      // fine oscillator trim
  output logic            O_CAP_TICK,       // capture timer clock
  output logic            O_ITMR_TICK,      // interval timer clock
  output logic            O_CLOCK_OUTPUT_PIN,         // clock output pin level
  output logic            O_XTAL_EN,        // crystal oscillator enable
  output logic      [1:0] O_PIN_OE_INHIBIT, // shared pin drivers off
  output logic            O_OSC24_RUN,      // fast oscillator runs
  output logic            O_CPU_FORCE_INT,  // cpu source forced int
  output logic            O_CPU_RESET,      // cpu held at address 0
  output logic            O_CPU_RUN,        // cpu may execute
  output logic            O_SLEEP_IRQ,      // sleep timer interrupt
  output logic            O_WDT_RESET       // watchdog reset event
);

  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam int SLP_W  = $clog2(SLEEP_DIV);

  if (HOLD_CYCLES < 1 || SLEEP_DIV < 2) begin : g_chk
    $error("scrw_top: HOLD_CYCLES >= 1 and SLEEP_DIV >= 2 required");
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  // ==========================================================================
  // oscillator and pin synchronisers
  // lanes: 0 fast osc, 1 slow osc, 2 crystal, 3 clock pin
  logic [3:0] async_in;
  logic [2:0] sync_reg [4];
  logic [3:0] stable_reg;
  logic [3:0] stable_next;

  assign async_in = {I_EXTERNAL_CLOCK_INPUT_PIN, I_XTAL_CLK, I_OSC32K, I_OSC24};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
        sync_reg[g] <= 3'h0;
      end else begin
        sync_reg[g] <= {sync_reg[g][1:0], async_in[g]};
      end
    end
    // a change counts only once stages two and three agree
    always_comb begin
      stable_next[g] = stable_reg[g];
      if (sync_reg[g][1] == sync_reg[g][2]) begin
        stable_next[g] = sync_reg[g][2];
      end
    end
  end

  // ==========================================================================
  // registers
  scrw_pkg::scrw_tmr_cfg_t   tmr_reg,  tmr_next;
  scrw_pkg::scrw_pin_cfg_t   pin_reg,  pin_next;
  logic [7:0]                lock_reg, lock_next;
  logic [7:0]                stat_reg, stat_next;
  logic [7:0]                rdata_reg, rdata_next;
  scrw_pkg::scrw_cpu_state_t st_reg,   st_next;
  logic                      wr_tmr, wr_pin, wr_lock, wr_wdt, wr_stat;
  logic                      wdr_next, wdr_reg;
  logic                      wake_done;

  assign wr_tmr  = I_WR && I_ADDR == scrw_pkg::ADDR_TMR_CFG;
  assign wr_pin  = I_WR && I_ADDR == scrw_pkg::ADDR_PIN_CFG;
  assign wr_lock = I_WR && I_ADDR == scrw_pkg::ADDR_LOCK_CFG;
  assign wr_wdt  = I_WR && I_ADDR == scrw_pkg::ADDR_WDT_CLR;
  assign wr_stat = I_WR && I_ADDR == scrw_pkg::ADDR_STATUS;

  always_comb begin
    tmr_next   = tmr_reg;
    pin_next   = pin_reg;
    lock_next  = lock_reg;
    stat_next  = stat_reg;
    rdata_next = 8'h00;
    if (wr_tmr) begin
      tmr_next = scrw_pkg::scrw_tmr_cfg_t'(I_WDATA);
    end
    if (wr_pin) begin
      pin_next = scrw_pkg::scrw_pin_cfg_t'(I_WDATA & scrw_pkg::PIN_CFG_WMASK); // RULE24
    end
    if (wr_lock) begin
      lock_next = I_WDATA & scrw_pkg::LOCK_WMASK; // RULE24
    end
    if (wr_stat) begin
      // flags may only be cleared; a one written there does nothing
      if (!I_WDATA[scrw_pkg::ST_WATCHDOG_RESET_FLAG_BIT]) begin
        stat_next[scrw_pkg::ST_WATCHDOG_RESET_FLAG_BIT] = 1'b0; // RULE15
      end
      if (!I_WDATA[scrw_pkg::ST_POWER_ON_FLAG_BIT]) begin
        stat_next[scrw_pkg::ST_POWER_ON_FLAG_BIT] = 1'b0; // RULE16
      end
      stat_next[scrw_pkg::ST_SLEEP_BIT] = I_WDATA[scrw_pkg::ST_SLEEP_BIT]; // RULE18
      stat_next[scrw_pkg::ST_STOP_BIT]  = I_WDATA[scrw_pkg::ST_STOP_BIT]; // RULE19
    end
    if (wake_done) begin
      stat_next[scrw_pkg::ST_SLEEP_BIT] = 1'b0;
    end
    if (I_RD) begin
      if (I_ADDR == scrw_pkg::ADDR_TMR_CFG) begin
        rdata_next = tmr_reg;
      end else if (I_ADDR == scrw_pkg::ADDR_PIN_CFG) begin
        rdata_next = pin_reg;
      end else if (I_ADDR == scrw_pkg::ADDR_LOCK_CFG) begin
        rdata_next = lock_reg;
      end else if (I_ADDR == scrw_pkg::ADDR_STATUS) begin
        rdata_next = stat_reg;
        rdata_next[scrw_pkg::ST_GLOBAL_INTERRUPT_STATUS_BIT] = I_GIE;
      end
    end
    // watchdog reset restores every default but records itself
    if (wdr_reg) begin
      tmr_next  = scrw_pkg::TMR_CFG_RST; // RULE12
      pin_next  = scrw_pkg::PIN_CFG_RST;
      lock_next = scrw_pkg::LOCK_CFG_RST;
      stat_next = 8'h00;
      stat_next[scrw_pkg::ST_WATCHDOG_RESET_FLAG_BIT] = 1'b1; // RULE15
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      tmr_reg   <= scrw_pkg::TMR_CFG_RST; // RULE12
      pin_reg   <= scrw_pkg::PIN_CFG_RST;
      lock_reg  <= scrw_pkg::LOCK_CFG_RST;
      stat_reg  <= scrw_pkg::STATUS_POR; // RULE16
      rdata_reg <= 8'h00;
    end else begin
      tmr_reg   <= tmr_next;
      pin_reg   <= pin_next;
      lock_reg  <= lock_next;
      stat_reg  <= stat_next;
      rdata_reg <= rdata_next; // RULE23
    end
  end

  assign O_RDATA = rdata_reg;

  // ==========================================================================
  // clock sources, filter, dividers
  logic [1:0] filt_cnt_reg, filt_cnt_next;
  logic       filt_reg, filt_next;
  logic       external_clock_input_lvl, ext_lvl, cpu_lvl_reg, cpu_lvl_next;
  logic [1:0] cpu_div_reg, cpu_div_next;
  logic [3:0] lvl, lvl_prev_reg, edge_s;
  logic [2:0] cap_cnt_reg, cap_cnt_next;
  logic [1:0] itm_cnt_reg, itm_cnt_next;
  logic       cap_src, itm_src, cap_tick_next, itm_tick_next, clock_output_pin_next;

  // short glitches on the pin are dropped unless the filter is bypassed
  assign external_clock_input_lvl = pin_reg.filt_dis ? stable_reg[3] : filt_reg; // RULE9
  assign ext_lvl   = pin_reg.xtal_en ? stable_reg[2] : external_clock_input_lvl; // RULE7
  // levels: 0 fast osc, 1 external, 2 slow osc, 3 cpu clock
  assign lvl       = {cpu_lvl_reg, stable_reg[1], ext_lvl, stable_reg[0]};
  assign edge_s    = lvl & ~lvl_prev_reg;

  always_comb begin
    filt_next     = filt_reg;
    filt_cnt_next = 2'h0;
    if (stable_reg[3] != filt_reg) begin
      filt_cnt_next = filt_cnt_reg + 2'h1;
      if (filt_cnt_reg == 2'(scrw_pkg::FILT_CYC - 1)) begin
        filt_next     = stable_reg[3]; // RULE9
        filt_cnt_next = 2'h0;
      end
    end
    // cpu clock is the fast oscillator over eight after reset
    cpu_div_next = cpu_div_reg;
    cpu_lvl_next = cpu_lvl_reg;
    if (edge_s[0]) begin
      cpu_div_next = cpu_div_reg + 2'h1; // RULE13
      if (cpu_div_reg == 2'h3) begin
        cpu_lvl_next = ~cpu_lvl_reg;
      end
    end
    case (tmr_reg.cap_sel) // RULE4
      scrw_pkg::SRC_INT24: cap_src = edge_s[0];
      scrw_pkg::SRC_EXT:   cap_src = edge_s[1];
      scrw_pkg::SRC_SLOW:  cap_src = edge_s[2];
      default:             cap_src = 1'b0;
    endcase
    cap_cnt_next  = cap_cnt_reg;
    cap_tick_next = 1'b0;
    if (cap_src) begin
      cap_cnt_next = cap_cnt_reg + 3'h1;
      if (cap_cnt_reg >= {tmr_reg.cap_div, 1'b1}) begin
        cap_cnt_next  = 3'h0; // RULE3
        cap_tick_next = 1'b1;
      end
    end
    case (tmr_reg.itm_sel) // RULE6
      scrw_pkg::SRC_INT24: itm_src = edge_s[0];
      scrw_pkg::SRC_EXT:   itm_src = edge_s[1];
      scrw_pkg::SRC_SLOW:  itm_src = edge_s[2];
      default:             itm_src = cap_tick_next;
    endcase
    itm_cnt_next  = itm_cnt_reg;
    itm_tick_next = 1'b0;
    if (itm_src) begin
      itm_cnt_next = itm_cnt_reg + 2'h1;
      if (itm_cnt_reg >= tmr_reg.itm_div) begin
        itm_cnt_next  = 2'h0; // RULE5
        itm_tick_next = 1'b1;
      end
    end
    clock_output_pin_next = lvl[pin_reg.out_sel]; // RULE10
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      filt_reg         <= 1'b0;
      filt_cnt_reg     <= 2'h0;
      stable_reg       <= 4'h0;
      lvl_prev_reg     <= 4'h0;
      cpu_div_reg      <= 2'h0;
      cpu_lvl_reg      <= 1'b0;
      cap_cnt_reg      <= 3'h0;
      itm_cnt_reg      <= 2'h0;
      O_CAP_TICK       <= 1'b0;
      O_ITMR_TICK      <= 1'b0;
      O_CLOCK_OUTPUT_PIN         <= 1'b0;
      O_XTAL_EN        <= 1'b0;
      O_PIN_OE_INHIBIT <= 2'h0;
    end else begin
      filt_reg         <= filt_next;
      filt_cnt_reg     <= filt_cnt_next;
      stable_reg       <= stable_next;
      lvl_prev_reg     <= lvl;
      cpu_div_reg      <= cpu_div_next;
      cpu_lvl_reg      <= cpu_lvl_next;
      cap_cnt_reg      <= cap_cnt_next;
      itm_cnt_reg      <= itm_cnt_next;
      O_CAP_TICK       <= cap_tick_next;
      O_ITMR_TICK      <= itm_tick_next;
      O_CLOCK_OUTPUT_PIN         <= clock_output_pin_next;
      O_XTAL_EN        <= pin_next.xtal_en;
      O_PIN_OE_INHIBIT <= {2{pin_next.xtal_en}}; // RULE7
    end
  end

  // ==========================================================================
  // oscillator lock trimming
  scrw_pkg::scrw_trim_t trim_reg, trim_next;
  logic                 lock_on;

  // trimming only makes sense while the internal osc clocks usb
  assign lock_on = !lock_reg[scrw_pkg::LOCK_DIS_BIT] && I_USB_INT_SRC
                   && st_reg != scrw_pkg::ST_SLEEP; // RULE2

  always_comb begin
    trim_next = trim_reg;
    if (lock_on && I_PKT_DONE) begin
      if (I_PKT_FAR && !lock_reg[scrw_pkg::LOCK_FINE_BIT]) begin // RULE1
        if (I_PKT_FAST && trim_reg.coarse != 4'h0) begin
          trim_next.coarse = trim_reg.coarse - 4'h1;
        end else if (!I_PKT_FAST && trim_reg.coarse != 4'hF) begin
          trim_next.coarse = trim_reg.coarse + 4'h1;
        end
      end else if (I_PKT_FAST && trim_reg.fine != 6'h00) begin
        trim_next.fine = trim_reg.fine - 6'h01; // RULE2
      end else if (!I_PKT_FAST && trim_reg.fine != 6'h3F) begin
        trim_next.fine = trim_reg.fine + 6'h01;
      end
    end
    if (wdr_reg) begin
      trim_next = {scrw_pkg::TRIM_CRS_RST, scrw_pkg::TRIM_FINE_RST};
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      trim_reg <= {scrw_pkg::TRIM_CRS_RST, scrw_pkg::TRIM_FINE_RST};
    end else begin
      trim_reg <= trim_next;
    end
  end

  assign O_TRIM_COARSE = trim_reg.coarse;
  assign O_TRIM_FINE   = trim_reg.fine;

  // ==========================================================================
  // sleep timer and watchdog
  logic [SLP_W-1:0] slp_cnt_reg, slp_cnt_next;
  logic [1:0]       wdt_cnt_reg, wdt_cnt_next;
  logic             slp_ovf;

  assign slp_ovf = edge_s[2] && slp_cnt_reg == SLP_W'(SLEEP_DIV - 1); // RULE20

  always_comb begin
    slp_cnt_next = slp_cnt_reg;
    wdt_cnt_next = wdt_cnt_reg;
    wdr_next     = 1'b0;
    if (edge_s[2]) begin
      slp_cnt_next = slp_ovf ? '0 : slp_cnt_reg + SLP_W'(1);
    end
    // watchdog runs only once the power-on flag has been cleared
    if (slp_ovf && !stat_reg[scrw_pkg::ST_POWER_ON_FLAG_BIT]) begin // RULE17
      wdt_cnt_next = wdt_cnt_reg + 2'h1;
      if (wdt_cnt_next == scrw_pkg::WDT_LIMIT) begin
        wdr_next     = 1'b1; // RULE21
        wdt_cnt_next = 2'h0;
      end
    end
    // a clear in the overflow cycle wins: firmware kicked in time
    if (wr_wdt) begin
      wdt_cnt_next = 2'h0; // RULE22
      wdr_next     = 1'b0;
      if (I_WDATA == scrw_pkg::WDT_CLR_KEY) begin
        slp_cnt_next = '0; // RULE22
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      slp_cnt_reg <= '0;
      wdt_cnt_reg <= 2'h0;
      wdr_reg     <= 1'b0;
      O_SLEEP_IRQ <= 1'b0;
    end else begin
      slp_cnt_reg <= slp_cnt_next;
      wdt_cnt_reg <= wdt_cnt_next;
      wdr_reg     <= wdr_next;
      O_SLEEP_IRQ <= slp_ovf; // RULE20
    end
  end

  assign O_WDT_RESET = wdr_reg;

  // ==========================================================================
  // cpu hold, run, sleep and stop sequencing
  logic [HOLD_W-1:0] hold_cnt_reg, hold_cnt_next;
  logic [1:0]        wake_cnt_reg, wake_cnt_next;

  assign wake_done = st_reg == scrw_pkg::ST_WAKE && edge_s[2]
                     && wake_cnt_reg == 2'(scrw_pkg::WAKE_SLOW_CYC - 1);

  always_comb begin
    st_next       = st_reg;
    hold_cnt_next = hold_cnt_reg;
    wake_cnt_next = wake_cnt_reg;
    case (st_reg)
      scrw_pkg::ST_HOLD: begin
        hold_cnt_next = hold_cnt_reg + HOLD_W'(1);
        if (hold_cnt_reg >= HOLD_W'(HOLD_CYCLES - 1)) begin
          st_next = scrw_pkg::ST_RUN; // RULE14
        end
      end
      scrw_pkg::ST_RUN: begin
        if (stat_reg[scrw_pkg::ST_STOP_BIT]) begin
          st_next = scrw_pkg::ST_STOP; // RULE19
        end else if (stat_reg[scrw_pkg::ST_SLEEP_BIT]) begin
          st_next = scrw_pkg::ST_SLEEP; // RULE18
        end
      end
      scrw_pkg::ST_SLEEP: begin
        wake_cnt_next = 2'h0;
        if (I_IRQ_PENDING) begin
          st_next = scrw_pkg::ST_WAKE; // RULE18
        end
      end
      scrw_pkg::ST_WAKE: begin
        if (edge_s[2]) begin
          wake_cnt_next = wake_cnt_reg + 2'h1;
        end
        if (wake_done) begin
          st_next = scrw_pkg::ST_RUN; // RULE11
        end
      end
      default: begin
        st_next = scrw_pkg::ST_STOP;
      end
    endcase
    // watchdog reset restarts the cpu after a single hold cycle
    if (wdr_reg) begin
      st_next       = scrw_pkg::ST_HOLD; // RULE13
      hold_cnt_next = HOLD_W'(HOLD_CYCLES - 1);
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      st_reg          <= scrw_pkg::ST_HOLD;
      hold_cnt_reg    <= '0;
      wake_cnt_reg    <= 2'h0;
      O_CPU_RESET     <= 1'b1;
      O_CPU_RUN       <= 1'b0;
      O_OSC24_RUN     <= 1'b1;
      O_CPU_FORCE_INT <= 1'b1;
    end else begin
      st_reg          <= st_next;
      hold_cnt_reg    <= hold_cnt_next;
      wake_cnt_reg    <= wake_cnt_next;
      O_CPU_RESET     <= st_next == scrw_pkg::ST_HOLD; // RULE13
      O_CPU_RUN       <= st_next == scrw_pkg::ST_RUN;
      O_OSC24_RUN     <= st_next != scrw_pkg::ST_SLEEP; // RULE11
      O_CPU_FORCE_INT <= st_next == scrw_pkg::ST_SLEEP
                         || st_next == scrw_pkg::ST_WAKE
                         || st_next == scrw_pkg::ST_HOLD;
    end
  end

  // ==========================================================================
  // checks
  unmapped_read_a: assert property ( // RULE23
    I_RD && I_ADDR == scrw_pkg::ADDR_WDT_CLR |=> O_RDATA == 8'h00)
    else $error("watchdog-clear register read back non-zero");
  power_on_flag_blocks_wdt_a: assert property ( // RULE17
    stat_reg[scrw_pkg::ST_POWER_ON_FLAG_BIT] |=> !O_WDT_RESET)
    else $error("watchdog reset while power-on flag set");
  wdt_third_ovf_a: assert property ( // RULE21
    $rose(O_WDT_RESET) |-> $past(wdt_cnt_reg) == 2'h2 && $past(slp_ovf))
    else $error("watchdog reset not on third overflow");
  wdt_clear_a: assert property ( // RULE22
    wr_wdt |=> wdt_cnt_reg == 2'h0 && !O_WDT_RESET)
    else $error("watchdog count not cleared by write");
  sleep_clear_a: assert property ( // RULE22
    wr_wdt && I_WDATA == 8'h38 |=> slp_cnt_reg == '0)
    else $error("sleep timer not cleared by key write");
  fine_only_a: assert property ( // RULE1
    lock_reg[scrw_pkg::LOCK_FINE_BIT] && !wr_lock && !wdr_reg
    |=> $stable(O_TRIM_COARSE))
    else $error("coarse trim moved in fine-only mode");
  lock_off_a: assert property ( // RULE2
    lock_reg[scrw_pkg::LOCK_DIS_BIT] && !wdr_reg |=> $stable(trim_reg))
    else $error("trim moved while lock disabled");
  sleep_osc_a: assert property ( // RULE11
    st_reg == scrw_pkg::ST_SLEEP |-> !O_OSC24_RUN && O_CPU_FORCE_INT)
    else $error("fast oscillator running during sleep");
  stop_halts_a: assert property ( // RULE19
    st_reg == scrw_pkg::ST_STOP && !wdr_reg |=> !O_CPU_RUN [*2])
    else $error("cpu ran while stopped");
  xtal_pins_a: assert property ( // RULE7
    pin_reg.xtal_en |-> O_PIN_OE_INHIBIT == 2'h3)
    else $error("pin drivers not inhibited by crystal");
  power_on_flag_no_set_a: assert property ( // RULE16
    !stat_reg[scrw_pkg::ST_POWER_ON_FLAG_BIT] |=> !stat_reg[scrw_pkg::ST_POWER_ON_FLAG_BIT])
    else $error("power-on flag set by software");

endmodule // scrw_top
`default_nettype wire

// ===== tb/scrw_tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CLK_SYS=0, I_RST=1, I_WR=0, I_RD=0, I_OSC24=0, I_OSC32K=0;
  logic I_XTAL_CLK=0, I_EXTERNAL_CLOCK_INPUT_PIN=0, I_USB_INT_SRC=1, I_PKT_DONE=0;
  logic I_PKT_FAST=0, I_PKT_FAR=0, I_IRQ_PENDING=0, I_GIE=0;
  logic [7:0] I_ADDR=8'h00, I_WDATA=8'h00, O_RDATA, r;
  logic [3:0] O_TRIM_COARSE;
  logic [5:0] O_TRIM_FINE;
  logic [1:0] O_PIN_OE_INHIBIT;
  logic O_CAP_TICK, O_ITMR_TICK, O_CLOCK_OUTPUT_PIN, O_XTAL_EN, O_OSC24_RUN;
  logic O_CPU_FORCE_INT, O_CPU_RESET, O_CPU_RUN, O_SLEEP_IRQ, O_WDT_RESET;
  int fail_count = 0, checked = 0, wdtn = 0, i;
  logic slow_en = 0;
  // rows: address, write data, expected read back
  logic [7:0] tab [5][3] = '{'{8'h31,8'hA5,8'hA5}, '{8'h32,8'hEF,8'h0F},
    '{8'h39,8'hFF,8'h03}, '{8'hE3,8'h38,8'h00}, '{8'h40,8'h55,8'h00}};
  scrw_top #(.HOLD_CYCLES(20), .SLEEP_DIV(4)) scrw_top_inst (.*);
  always #4 I_CLK_SYS = ~I_CLK_SYS;
  // oscillators move on bench edges: fast period 6 cycles, slow 16
  int ph = 0;
  always @(posedge I_CLK_SYS) begin
    ph <= ph + 1;
    if (ph % 3 == 2) I_OSC24 <= ~I_OSC24;
    if (slow_en && ph % 8 == 7) I_OSC32K <= ~I_OSC32K;
  end
  always @(posedge I_CLK_SYS) if (O_WDT_RESET === 1'b1) wdtn++;
  // ==========================================================================
  // bus and compare tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLK_SYS);
    I_ADDR <= a; I_WDATA <= d; I_WR <= 1'b1;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge I_CLK_SYS);
    I_ADDR <= a; I_RD <= 1'b1;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0;
    @(negedge I_CLK_SYS);
    r = O_RDATA;
  endtask
  task automatic pkt(input logic far);
    @(posedge I_CLK_SYS);
    I_PKT_DONE <= 1'b1; I_PKT_FAR <= far; I_PKT_FAST <= 1'b0;
    @(posedge I_CLK_SYS);
    I_PKT_DONE <= 1'b0;
    @(negedge I_CLK_SYS);
  endtask
  task automatic span(input int w);
    int n, k;
    logic p, t;
    k = 0;
    p = 1'b1;
    r = 8'h00;
    // r ends as the cycle count between two ticks or clock-out rises
    for (n = 0; n < 400 && k < 2; n++) begin
      @(posedge I_CLK_SYS); #1;
      r = r + 8'h01;
      t = w == 0 ? O_CAP_TICK : w == 1 ? O_ITMR_TICK : O_CLOCK_OUTPUT_PIN & ~p;
      p = O_CLOCK_OUTPUT_PIN;
      if (t === 1'b1) begin
        if (k == 0) r = 8'h00;
        k++;
      end
    end
    if (k < 2) begin
      fail_count++;
      $display("[ERR] %0t tick wait ran out", $time);
      results();
    end
  endtask
  task automatic waitfor(input int w);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge I_CLK_SYS); #1;
      if ((w == 0 && O_CPU_RUN) || (w == 1 && O_SLEEP_IRQ)) return;
      if (w == 2 && O_WDT_RESET) return;
    end
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    results();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge I_CLK_SYS);
    I_RST <= 1'b0;
    @(negedge I_CLK_SYS);
    chk({6'h0, O_CPU_RESET, O_CPU_FORCE_INT}, 8'h03);
    chk({O_TRIM_COARSE, O_TRIM_FINE[3:0]}, 8'h80);
    rd(8'h31); chk(r, 8'h8F);
    rd(8'hFF); chk(r, 8'h10);
    chk({7'h0, O_CPU_RUN}, 8'h00);
    waitfor(0);
    for (i = 0; i < 5; i++) begin
      wr(tab[i][0], tab[i][1]);
      rd(tab[i][0]); chk(r, tab[i][2]);
    end
    chk({6'h0, O_PIN_OE_INHIBIT}, 8'h03);
    wr(8'h32, 8'h1B); rd(8'h32); chk(r, 8'h1B);
    chk({7'h0, O_XTAL_EN}, 8'h01);
    // expected gaps are the divisor times the six-cycle fast period
    span(2); chk(r, 8'h30);
    wr(8'h39, 8'h00); pkt(1'b1); chk({4'h0, O_TRIM_COARSE}, 8'h09);
    wr(8'h39, 8'h02); pkt(1'b1); chk({4'h0, O_TRIM_COARSE}, 8'h09);
    chk({2'h0, O_TRIM_FINE}, 8'h21);
    wr(8'h39, 8'h01); pkt(1'b0); chk({2'h0, O_TRIM_FINE}, 8'h21);
    wr(8'h31, 8'hCB);
    span(0); chk(r, 8'h30);
    span(1); chk(r, 8'h90);
    wr(8'h31, 8'h00);
    span(0); chk(r, 8'h0C);
    span(1); chk(r, 8'h06);
    slow_en = 1'b1;
    // keep the power-on flag so the watchdog stays off while asleep
    wr(8'hFF, 8'h18); repeat (2) @(negedge I_CLK_SYS);
    chk({6'h0, O_OSC24_RUN, O_CPU_FORCE_INT}, 8'h01);
    waitfor(1); waitfor(1); waitfor(1); waitfor(1);
    chk({7'h0, O_OSC24_RUN}, 8'h00);
    chk(wdtn[7:0], 8'h00);
    I_IRQ_PENDING <= 1'b1;
    waitfor(0);
    I_IRQ_PENDING <= 1'b0;
    rd(8'hFF); chk(r, 8'h10);
    wr(8'hFF, 8'h00);
    waitfor(2);
    @(negedge I_CLK_SYS);
    rd(8'hFF); chk(r, 8'h20);
    rd(8'h32); chk(r, 8'h00);
    wr(8'hFF, 8'h00); rd(8'hFF); chk(r, 8'h00);
    wr(8'hFF, 8'h30); rd(8'hFF); chk(r, 8'h00);
    wr(8'hE3, 8'h38); chk(wdtn[7:0], 8'h01);
    chk({7'h0, O_CPU_RUN}, 8'h01);
    wr(8'hFF, 8'h01); repeat (4) @(negedge I_CLK_SYS);
    chk({7'h0, O_CPU_RUN}, 8'h00);
    I_RST <= 1'b1;
    repeat (2) @(posedge I_CLK_SYS);
    I_RST <= 1'b0;
    rd(8'hFF); chk(r, 8'h10);
    chk({6'h0, O_CPU_RESET, O_CPU_RUN}, 8'h02);
    results();
  end
endmodule // tb
`default_nettype wire
